// File: rtl/ifb_addr_ptr.sv
// Fetch address pointer driving the code address lines
`include "ifb_defs.svh"

module ifb_addr_ptr (
  input wire logic clk_in,
  input wire logic rst_in,
  input ifb_pkg::ifb_ptr_op_t op_in,
  input wire logic [`IFB_ADDR_W-1:0] load_addr_in,
  output logic [`IFB_ADDR_W-1:0] addr_out
);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_out <= `IFB_RESET_VEC;
    end else begin
      case (op_in)
        ifb_pkg::IFB_PTR_INC: addr_out <= addr_out + `IFB_ADDR_ONE;
        ifb_pkg::IFB_PTR_LOAD: addr_out <= load_addr_in;
        default: addr_out <= addr_out;
      endcase
    end
  end

endmodule

// File: rtl/ifb_defs.svh
// Constants of the instruction fetch bus unit
`ifndef IFB_DEFS_SVH
`define IFB_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define IFB_ADDR_W 30
`define IFB_WORD_W 32

// ----------------------------------------------------------------
// Reply codes, high bit first
// ----------------------------------------------------------------
`define IFB_REPLY_RSVD 2'h0
`define IFB_REPLY_WAIT 2'h1
`define IFB_REPLY_SUCCESS 2'h2
`define IFB_REPLY_FAULT 2'h3

// ----------------------------------------------------------------
// Word addresses
// ----------------------------------------------------------------
`define IFB_RESET_VEC 30'h00000000
`define IFB_EXC_VEC 30'h00000001
`define IFB_ADDR_ONE 30'h00000001

`endif

// File: rtl/ifb_fetch.sv
// Pipelined instruction fetch bus unit
// Contract
// - Fetch every cycle except three null cases
// - Stall repeats address phase of next instruction
// - Replies to stall repeats are ignored
// - One null transaction after reset, strobe floating
// - Invalid pointer load gives null transaction
// - Taken fault: null, then exception vector fetch
// - Each access reads one 32-bit word
// - Address phase then reply phase, one clock each
// - Address, strobe, select driven at phase start
// - Reply 10 success, 01 wait, 11 fault
// - Null transaction drives address, ignores reply
// - Address phase overlaps previous reply phase
// - Wait repeats next address phase until success
// - Access after a fault is ignored
// - Next normal address phase follows fault reply
// - Discarded fault repeats ignored access, no exception
`include "ifb_defs.svh"

module ifb_fetch (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic core_stall_in,
  input wire logic core_redirect_in,
  input wire logic core_redirect_valid_in,
  input wire logic [`IFB_ADDR_W-1:0] core_redirect_addr_in,
  input wire logic core_super_in,
  input wire logic core_discard_in,
  input wire logic [`IFB_WORD_W-1:0] code_word_bus_in,
  input wire logic [1:0] code_reply_in,
  output logic [`IFB_ADDR_W-1:0] code_address_out,
  output logic code_fetch_strobe_out,
  output logic code_fetch_strobe_oe_out,
  output logic code_super_out,
  output logic instr_valid_out,
  output logic [`IFB_ADDR_W-1:0] instr_addr_out,
  output logic [`IFB_WORD_W-1:0] instr_word_out,
  output logic fetch_fault_out,
  output logic fetch_exception_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ifb_pkg::ifb_state_t state_q;
  ifb_pkg::ifb_state_t state_d;
  ifb_pkg::ifb_reply_t reply;
  ifb_pkg::ifb_ptr_op_t ptr_op;
  ifb_pkg::ifb_ctl_t ctl_q;
  ifb_pkg::ifb_ctl_t ctl_d;
  ifb_pkg::ifb_instr_t instr_q;
  logic [`IFB_ADDR_W-1:0] ptr_load;
  logic [`IFB_ADDR_W-1:0] prev_addr_q;
  logic cur_live_q;
  logic cur_live_d;
  logic prev_live_q;
  logic prev_live_d;
  logic rep_wait;
  logic rep_fault;
  logic rep_ok;
  logic fault_q;
  logic exc_q;

  ifb_reply_dec u_reply_dec (
    .code_reply_in(code_reply_in),
    .reply_out(reply)
  );

  ifb_addr_ptr u_addr_ptr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .op_in(ptr_op),
    .load_addr_in(ptr_load),
    .addr_out(code_address_out)
  );

  // ----------------------------------------------------------------
  // Reply qualification
  // ----------------------------------------------------------------
  // Reply belongs to last cycle's address phase; null or stalled ones are ignored
  assign rep_wait = prev_live_q && (reply == ifb_pkg::IFB_REP_WAIT ||
                    reply == ifb_pkg::IFB_REP_RSVD);
  assign rep_fault = prev_live_q && (reply == ifb_pkg::IFB_REP_FAULT);
  assign rep_ok = !rep_wait && !rep_fault;

  // ----------------------------------------------------------------
  // Next transaction
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ptr_op = ifb_pkg::IFB_PTR_HOLD;
    ptr_load = core_redirect_addr_in;
    cur_live_d = !core_stall_in;
    prev_live_d = cur_live_q;
    ctl_d.strobe = 1'b1;
    ctl_d.strobe_oe = 1'b1;
    ctl_d.super_sel = core_super_in;
    case (state_q)
      ifb_pkg::IFB_ST_RESET_NULL: begin
        state_d = ifb_pkg::IFB_ST_RUN;
        prev_live_d = 1'b0;
      end
      ifb_pkg::IFB_ST_RUN: begin
        if (rep_fault) begin
          prev_live_d = 1'b0;
          if (core_discard_in) begin
            ptr_op = ifb_pkg::IFB_PTR_HOLD;
          end else begin
            state_d = ifb_pkg::IFB_ST_FAULT_NULL;
            ctl_d.strobe = 1'b0;
            cur_live_d = 1'b0;
          end
        end else if (rep_wait) begin
          prev_live_d = 1'b1;
          cur_live_d = cur_live_q;
          ctl_d.super_sel = ctl_q.super_sel;
        end else if (core_redirect_in && !core_redirect_valid_in) begin
          state_d = ifb_pkg::IFB_ST_PTR_INVALID;
          ctl_d.strobe = 1'b0;
          cur_live_d = 1'b0;
        end else if (core_redirect_in) begin
          ptr_op = ifb_pkg::IFB_PTR_LOAD;
        end else if (cur_live_q) begin
          ptr_op = ifb_pkg::IFB_PTR_INC;
        end
      end
      ifb_pkg::IFB_ST_FAULT_NULL: begin
        state_d = ifb_pkg::IFB_ST_RUN;
        ptr_op = ifb_pkg::IFB_PTR_LOAD;
        ptr_load = `IFB_EXC_VEC;
        prev_live_d = 1'b0;
      end
      ifb_pkg::IFB_ST_PTR_INVALID: begin
        prev_live_d = 1'b0;
        if (core_redirect_in && core_redirect_valid_in) begin
          state_d = ifb_pkg::IFB_ST_RUN;
          ptr_op = ifb_pkg::IFB_PTR_LOAD;
        end else begin
          ctl_d.strobe = 1'b0;
          cur_live_d = 1'b0;
        end
      end
      default: begin
        state_d = ifb_pkg::IFB_ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Phase registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ifb_pkg::IFB_ST_RESET_NULL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur_live_q <= 1'b0;
      prev_live_q <= 1'b0;
      prev_addr_q <= `IFB_RESET_VEC;
    end else begin
      cur_live_q <= cur_live_d;
      prev_live_q <= prev_live_d;
      if (!rep_wait) begin
        prev_addr_q <= code_address_out;
      end
    end
  end

  assign code_fetch_strobe_out = ctl_q.strobe;
  assign code_fetch_strobe_oe_out = ctl_q.strobe_oe;
  assign code_super_out = ctl_q.super_sel;

  // ----------------------------------------------------------------
  // Word delivery and events
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr_q <= '0;
    end else begin
      instr_q.valid <= prev_live_q && rep_ok;
      if (prev_live_q && rep_ok) begin
        instr_q.addr <= prev_addr_q;
        instr_q.word <= code_word_bus_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fault_q <= 1'b0;
      exc_q <= 1'b0;
    end else begin
      fault_q <= rep_fault;
      exc_q <= rep_fault && !core_discard_in && state_q == ifb_pkg::IFB_ST_RUN;
    end
  end

  assign instr_valid_out = instr_q.valid;
  assign instr_addr_out = instr_q.addr;
  assign instr_word_out = instr_q.word;
  assign fetch_fault_out = fault_q;
  assign fetch_exception_out = exc_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic run_fault;
  assign run_fault = rep_fault && state_q == ifb_pkg::IFB_ST_RUN;

  chk_reset_null: assert property (@(posedge clk_in)
    $fell(rst_in) |-> !code_fetch_strobe_oe_out ##1 code_fetch_strobe_oe_out)
    else $error("reset null transaction wrong");
  chk_fetch_every: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_RUN |-> code_fetch_strobe_out && code_fetch_strobe_oe_out)
    else $error("fetch strobe missing in run");
  chk_wait_repeat: assert property (@(posedge clk_in) disable iff (rst_in)
    rep_wait && state_q == ifb_pkg::IFB_ST_RUN |=> $stable(code_address_out) &&
    code_fetch_strobe_out && prev_live_q)
    else $error("wait did not repeat address phase");
  chk_stall_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
    !prev_live_q |=> !instr_valid_out)
    else $error("ignored reply delivered a word");
  chk_stall_repeat: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_RUN && !cur_live_q && !prev_live_q && !core_redirect_in
    |=> $stable(code_address_out))
    else $error("stall did not repeat address");
  chk_fault_null: assert property (@(posedge clk_in) disable iff (rst_in)
    run_fault && !core_discard_in |=> !code_fetch_strobe_out ##1
    (code_fetch_strobe_out && code_address_out == `IFB_EXC_VEC))
    else $error("fault exception sequence wrong");
  chk_fault_discard: assert property (@(posedge clk_in) disable iff (rst_in)
    run_fault && core_discard_in |=> $stable(code_address_out) && code_fetch_strobe_out &&
    !fetch_exception_out)
    else $error("discarded fault did not repeat access");
  chk_fault_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
    rep_fault |=> !prev_live_q ##1 !instr_valid_out)
    else $error("access after fault not ignored");
  chk_invalid_null: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_RUN && rep_ok && core_redirect_in && !core_redirect_valid_in
    |=> !code_fetch_strobe_out)
    else $error("invalid pointer did not give null");
  chk_word_deliver: assert property (@(posedge clk_in) disable iff (rst_in)
    prev_live_q && reply == ifb_pkg::IFB_REP_SUCCESS |=>
    instr_valid_out && instr_word_out == $past(code_word_bus_in))
    else $error("successful word not delivered");
  chk_reset_addr: assert property (@(posedge clk_in)
    $fell(rst_in) |-> code_address_out == `IFB_RESET_VEC)
    else $error("reset address wrong");
  chk_strobe_enable: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q != ifb_pkg::IFB_ST_RESET_NULL |-> code_fetch_strobe_oe_out)
    else $error("strobe left floating after reset null");
  chk_null_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
    !code_fetch_strobe_out |=> !prev_live_q)
    else $error("reply to null transaction taken");
  chk_fault_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    fetch_fault_out |=> !fetch_fault_out)
    else $error("fault taken on access after fault");
  chk_exc_null: assert property (@(posedge clk_in) disable iff (rst_in)
    fetch_exception_out |-> fetch_fault_out && !code_fetch_strobe_out)
    else $error("exception without null transaction");
  chk_invalid_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_PTR_INVALID && !(core_redirect_in && core_redirect_valid_in)
    |=> !code_fetch_strobe_out && $stable(code_address_out))
    else $error("invalid pointer did not hold null");
  chk_redirect_load: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_PTR_INVALID && core_redirect_in && core_redirect_valid_in
    |=> code_fetch_strobe_out && code_address_out == $past(core_redirect_addr_in))
    else $error("valid pointer did not resume fetch");
  chk_wait_super: assert property (@(posedge clk_in) disable iff (rst_in)
    rep_wait && state_q == ifb_pkg::IFB_ST_RUN |=> $stable(code_super_out))
    else $error("wait changed supervisor select");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------

  cov_wait: cover property (@(posedge clk_in) disable iff (rst_in) rep_wait ##1 rep_ok);
  cov_fault_exc: cover property (@(posedge clk_in) disable iff (rst_in)
    run_fault && !core_discard_in);
  cov_stall: cover property (@(posedge clk_in) disable iff (rst_in)
    !cur_live_q ##1 cur_live_q);
  cov_fault_discard: cover property (@(posedge clk_in) disable iff (rst_in)
    run_fault && core_discard_in);
  cov_invalid_exit: cover property (@(posedge clk_in) disable iff (rst_in)
    state_q == ifb_pkg::IFB_ST_PTR_INVALID ##1 state_q == ifb_pkg::IFB_ST_RUN);

endmodule

// File: rtl/ifb_pkg.sv
// Types of the instruction fetch bus unit
package ifb_pkg;

  typedef enum logic [1:0] {
    IFB_REP_RSVD = 2'b00,
    IFB_REP_WAIT = 2'b01,
    IFB_REP_SUCCESS = 2'b10,
    IFB_REP_FAULT = 2'b11
  } ifb_reply_t;

  typedef enum logic [1:0] {
    IFB_ST_RESET_NULL = 2'b00,
    IFB_ST_RUN = 2'b01,
    IFB_ST_FAULT_NULL = 2'b10,
    IFB_ST_PTR_INVALID = 2'b11
  } ifb_state_t;

  typedef enum logic [1:0] {
    IFB_PTR_HOLD = 2'b00,
    IFB_PTR_INC = 2'b01,
    IFB_PTR_LOAD = 2'b10
  } ifb_ptr_op_t;

  typedef struct packed {
    logic strobe;
    logic strobe_oe;
    logic super_sel;
  } ifb_ctl_t;

  typedef struct packed {
    logic valid;
    logic [29:0] addr;
    logic [31:0] word;
  } ifb_instr_t;

endpackage

// File: rtl/ifb_reply_dec.sv
// Decoder of the two reply lines
`include "ifb_defs.svh"

module ifb_reply_dec (
  input wire logic [1:0] code_reply_in,
  output ifb_pkg::ifb_reply_t reply_out
);

  always_comb begin
    case (code_reply_in)
      `IFB_REPLY_SUCCESS: reply_out = ifb_pkg::IFB_REP_SUCCESS;
      `IFB_REPLY_WAIT: reply_out = ifb_pkg::IFB_REP_WAIT;
      `IFB_REPLY_FAULT: reply_out = ifb_pkg::IFB_REP_FAULT;
      default: reply_out = ifb_pkg::IFB_REP_RSVD;
    endcase
  end

endmodule

// File: test/ifb_mem_model.sv
// Responder model on the far side of the instruction fetch bus
`include "ifb_defs.svh"

module ifb_mem_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [29:0] code_address_in,
  input wire logic code_fetch_strobe_in,
  input wire logic [1:0] reply_sel_in,
  output logic [31:0] code_word_bus_out,
  output logic [1:0] code_reply_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Address capture
  // ----------------------------------------
  logic [29:0] addr_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_q <= 30'h0;
    end else if (code_fetch_strobe_in === 1'b1 && reply_sel_in != `IFB_REPLY_WAIT) begin
      addr_q <= code_address_in;
    end
  end

  // ----------------------------------------
  // Reply phase
  // ----------------------------------------
  always_comb begin
    code_reply_out = reply_sel_in;
    if (reply_sel_in == `IFB_REPLY_SUCCESS) begin
      code_word_bus_out = {2'h2, addr_q};
    end else begin
      code_word_bus_out = ~{2'h2, addr_q};
    end
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench of the instruction fetch unit
`include "ifb_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic stall = 1'b0;
  logic redir = 1'b0;
  logic redir_ok = 1'b0;
  logic sup = 1'b0;
  logic discard = 1'b0;
  logic [29:0] redir_addr = 30'h0;
  logic [1:0] rep_sel = 2'h2;
  logic [31:0] word;
  logic [31:0] i_word;
  logic [1:0] reply;
  logic [29:0] addr;
  logic [29:0] i_addr;
  logic strobe;
  logic strobe_oe;
  logic super_sel;
  logic i_valid;
  logic flt;
  logic exc;
  wire fetch_pin;
  logic [29:0] q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int n_null = 0;
  int n_flt = 0;
  int n_exc = 0;

  always #2 clk_in = ~clk_in;
  assign fetch_pin = strobe_oe ? strobe : 1'bz;

  ifb_fetch u_dut (.clk_in(clk_in), .rst_in(rst_in), .core_stall_in(stall),
    .core_redirect_in(redir), .core_redirect_valid_in(redir_ok),
    .core_redirect_addr_in(redir_addr), .core_super_in(sup), .core_discard_in(discard),
    .code_word_bus_in(word), .code_reply_in(reply), .code_address_out(addr),
    .code_fetch_strobe_out(strobe), .code_fetch_strobe_oe_out(strobe_oe),
    .code_super_out(super_sel), .instr_valid_out(i_valid), .instr_addr_out(i_addr),
    .instr_word_out(i_word), .fetch_fault_out(flt), .fetch_exception_out(exc));

  ifb_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .code_address_in(addr),
    .code_fetch_strobe_in(fetch_pin), .reply_sel_in(rep_sel),
    .code_word_bus_out(word), .code_reply_out(reply));

  always @(posedge clk_in) begin
    if (!rst_in) begin
      if (i_valid === 1'b1) begin
        q.push_back(i_addr);
        chk(i_word, {2'h2, i_addr});
      end
      n_null += (strobe !== 1'b1);
      n_flt += (flt === 1'b1);
      n_exc += (exc === 1'b1);
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic clr();
    q.delete();
    n_null = 0;
    n_flt = 0;
    n_exc = 0;
  endtask

  task automatic chk_seq(input int s);
    for (int i = s + 1; i < q.size(); i++) begin
      chk(32'(q[i]), 32'(q[i-1] + 30'h1));
    end
  endtask

  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    step(8);
    rst_in = 1'b0;
    chk(32'({strobe_oe, strobe}), 32'h0);
    step(1);
    chk(32'({strobe_oe, strobe, addr}), 32'hC0000000);
    sup = 1'b1;
    clr();
    step(8);
    chk(32'(super_sel), 32'h1);
    chk(32'(q[0]), 32'h0);
    chk(32'(n_null), 32'h0);
    chk_seq(0);
    $display("reset test done");
  endtask

  task automatic t_wait();
    logic [29:0] a;
    rep_sel = `IFB_REPLY_WAIT;
    a = addr;
    step(2);
    clr();
    step(1);
    chk(32'(addr), 32'(a));
    chk(32'(q.size()), 32'h0);
    rep_sel = `IFB_REPLY_SUCCESS;
    step(6);
    chk(32'(q[0]), 32'(a - 30'h1));
    chk_seq(0);
    $display("wait test done");
  endtask

  task automatic t_stall();
    logic [29:0] a;
    clr();
    stall = 1'b1;
    step(2);
    rep_sel = `IFB_REPLY_FAULT;
    a = addr;
    step(2);
    chk(32'(addr), 32'(a));
    stall = 1'b0;
    rep_sel = `IFB_REPLY_SUCCESS;
    step(6);
    chk(32'(n_flt), 32'h0);
    chk_seq(0);
    $display("stall test done");
  endtask

  task automatic t_fault(input logic d);
    logic [29:0] a;
    clr();
    rep_sel = `IFB_REPLY_FAULT;
    discard = d;
    a = addr;
    step(1);
    rep_sel = `IFB_REPLY_SUCCESS;
    discard = 1'b0;
    step(8);
    chk(32'(n_flt), 32'h1);
    chk(32'(n_exc), 32'(!d));
    chk(32'(n_null), 32'(!d));
    chk(32'(q[1]), d ? 32'(a) : 32'(`IFB_EXC_VEC));
    chk_seq(1);
    $display("fault test done");
  endtask

  task automatic t_invalid();
    redir = 1'b1;
    step(1);
    redir = 1'b0;
    step(2);
    clr();
    step(4);
    chk(32'(n_null), 32'h4);
    chk(32'(q.size()), 32'h0);
    redir = 1'b1;
    redir_ok = 1'b1;
    redir_addr = 30'h100;
    step(1);
    redir = 1'b0;
    step(6);
    chk(32'(q[0]), 32'h100);
    chk_seq(0);
    $display("invalid pointer test done");
  endtask

  initial begin
    #8000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    t_reset();
    t_wait();
    t_stall();
    t_fault(1'b0);
    t_fault(1'b1);
    t_invalid();
    tally_and_finish();
  end
endmodule
